/* File: slcr_pkg.sv */
// constants for the serializer link configuration register bank
package slcr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK_OUTPUT_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_RESERVED_SIX = 8'h06;
  localparam logic [7:0] ADDR_RESERVED_SEVEN = 8'h07;
  localparam logic [7:0] ADDR_CABLE_FAULT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESERVED_TWELVE = 8'h0C;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ADDR_SKIP = 7;
  localparam int BIT_FILTER_OFF = 6;
  localparam int SWING_HI = 5;
  localparam int SWING_LO = 4;
  localparam int EMPH_HI = 3;
  localparam int EMPH_LO = 0;
  // ----------------------------------------------------------------
  // reset values and status pad
  // ----------------------------------------------------------------
  localparam logic RST_ADDR_SKIP = 1'h0;
  localparam logic RST_FILTER_OFF = 1'h1;
  localparam logic [1:0] RST_SWING = 2'h3;
  localparam logic [3:0] RST_EMPH = 4'h0;
  localparam logic [7:0] RST_RESERVED_SIX = 8'h40;
  localparam logic [7:0] RST_RESERVED_SEVEN = 8'h22;
  localparam logic [7:0] RST_RESERVED_TWELVE = 8'h70;
  localparam logic [1:0] WIRE_NORMAL = 2'h2;
  localparam logic [3:0] STATUS_PAD = 4'h0;
  // ----------------------------------------------------------------
  // swing codes, millivolts
  // ----------------------------------------------------------------
  localparam logic [1:0] SWING_200 = 2'h1;
  localparam logic [1:0] SWING_300 = 2'h2;
  localparam logic [1:0] SWING_400 = 2'h3;
  localparam logic [8:0] MV_200 = 9'h0C8;
  localparam logic [8:0] MV_300 = 9'h12C;
  localparam logic [8:0] MV_400 = 9'h190;
endpackage

/* File: slcr_regs.sv */
// serializer link configuration and cable fault status registers
`timescale 1ns/100ps
module slcr_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cable fault monitor, asynchronous
  input wire logic [1:0] neg_wire_fault_in,
  input wire logic [1:0] pos_wire_fault_in,
  // configuration outputs
  output logic addr_byte_skip,
  output logic filter_loop_off,
  output logic [1:0] output_swing_level,
  output logic [8:0] swing_mv,
  output logic swing_code_bad,
  output logic [3:0] emphasis_setting
);
  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic skip_q, skip_d;
  logic floff_q, floff_d;
  logic [1:0] swing_q, swing_d;
  logic [3:0] emph_q, emph_d;
  logic [7:0] rsv6_q, rsv6_d;
  logic [7:0] rsv7_q, rsv7_d;
  logic [7:0] rsv12_q, rsv12_d;
  logic [8:0] mv_q, mv_d;
  logic bad_q, bad_d;

  function automatic logic [8:0] swing_to_mv(input logic [1:0] code);
    case (code)
      slcr_pkg::SWING_200: swing_to_mv = slcr_pkg::MV_200;
      slcr_pkg::SWING_300: swing_to_mv = slcr_pkg::MV_300;
      slcr_pkg::SWING_400: swing_to_mv = slcr_pkg::MV_400;
      default: swing_to_mv = 9'h000;
    endcase
  endfunction

  always_comb begin
    skip_d = skip_q;
    floff_d = floff_q;
    swing_d = swing_q;
    emph_d = emph_q;
    rsv6_d = rsv6_q;
    rsv7_d = rsv7_q;
    rsv12_d = rsv12_q;
    if (reg_wr) begin
      case (reg_addr)
        slcr_pkg::ADDR_LINK_OUTPUT_CONFIG: begin
          skip_d = reg_wdata[slcr_pkg::BIT_ADDR_SKIP];
          floff_d = reg_wdata[slcr_pkg::BIT_FILTER_OFF];
          swing_d = reg_wdata[slcr_pkg::SWING_HI:slcr_pkg::SWING_LO];
          emph_d = reg_wdata[slcr_pkg::EMPH_HI:slcr_pkg::EMPH_LO];
        end
        slcr_pkg::ADDR_RESERVED_SIX: rsv6_d = reg_wdata;
        slcr_pkg::ADDR_RESERVED_SEVEN: rsv7_d = reg_wdata;
        slcr_pkg::ADDR_RESERVED_TWELVE: rsv12_d = reg_wdata;
        default: ;
      endcase
    end
    mv_d = swing_to_mv(swing_d);
    bad_d = (mv_d == 9'h000);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_q <= slcr_pkg::RST_ADDR_SKIP;
      floff_q <= slcr_pkg::RST_FILTER_OFF;
      swing_q <= slcr_pkg::RST_SWING;
      emph_q <= slcr_pkg::RST_EMPH;
      rsv6_q <= slcr_pkg::RST_RESERVED_SIX;
      rsv7_q <= slcr_pkg::RST_RESERVED_SEVEN;
      rsv12_q <= slcr_pkg::RST_RESERVED_TWELVE;
      mv_q <= slcr_pkg::MV_400;
      bad_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
      floff_q <= floff_d;
      swing_q <= swing_d;
      emph_q <= emph_d;
      rsv6_q <= rsv6_d;
      rsv7_q <= rsv7_d;
      rsv12_q <= rsv12_d;
      mv_q <= mv_d;
      bad_q <= bad_d;
    end
  end

  assign addr_byte_skip = skip_q;
  assign filter_loop_off = floff_q;
  assign output_swing_level = swing_q;
  assign emphasis_setting = emph_q;
  assign swing_mv = mv_q;
  assign swing_code_bad = bad_q;

  // ----------------------------------------------------------------
  // fault input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] flt_s1_q, flt_s2_q, flt_s1_d, flt_s2_d;
  logic [3:0] flt_s3_q, flt_s3_d, stat_q, stat_d;

  always_comb begin
    flt_s1_d = {neg_wire_fault_in, pos_wire_fault_in};
    flt_s2_d = flt_s1_q;
    flt_s3_d = flt_s2_q;
    // codes cross bit by bit; take a word only once seen twice alike
    stat_d = stat_q;
    if (flt_s2_q == flt_s3_q) begin
      stat_d = flt_s3_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flt_s1_q <= {slcr_pkg::WIRE_NORMAL, slcr_pkg::WIRE_NORMAL};
      flt_s2_q <= {slcr_pkg::WIRE_NORMAL, slcr_pkg::WIRE_NORMAL};
      flt_s3_q <= {slcr_pkg::WIRE_NORMAL, slcr_pkg::WIRE_NORMAL};
      stat_q <= {slcr_pkg::WIRE_NORMAL, slcr_pkg::WIRE_NORMAL};
    end else begin
      flt_s1_q <= flt_s1_d;
      flt_s2_q <= flt_s2_d;
      flt_s3_q <= flt_s3_d;
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        slcr_pkg::ADDR_LINK_OUTPUT_CONFIG:
          rdata_d = {skip_q, floff_q, swing_q, emph_q};
        slcr_pkg::ADDR_RESERVED_SIX: rdata_d = rsv6_q;
        slcr_pkg::ADDR_RESERVED_SEVEN: rdata_d = rsv7_q;
        slcr_pkg::ADDR_CABLE_FAULT_STATUS:
          rdata_d = {slcr_pkg::STATUS_PAD, stat_q};
        slcr_pkg::ADDR_RESERVED_TWELVE: rdata_d = rsv12_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    reg_wr && reg_addr == slcr_pkg::ADDR_LINK_OUTPUT_CONFIG;
  endsequence

  a_skip_bit_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_cfg_write |=> addr_byte_skip == $past(reg_wdata[7]))
    else $error("skip bit not taken from write");

  a_skip_bit_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !reg_wr |=> $stable(addr_byte_skip))
    else $error("skip bit changed without write");

  a_swing_decode: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    output_swing_level == 2'h2 |-> swing_mv == 9'h12C && !swing_code_bad)
    else $error("swing 300mV decode wrong");

  a_swing_unused: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    output_swing_level == 2'h0 |-> swing_code_bad && swing_mv == 9'h000)
    else $error("unused swing code not flagged");

  a_swing_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_cfg_write |=> output_swing_level == $past(reg_wdata[5:4]))
    else $error("swing field not written");

  a_neg_wire_read: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == slcr_pkg::ADDR_CABLE_FAULT_STATUS
    |=> reg_rdata[3:2] == $past(stat_q[3:2]))
    else $error("negative wire field wrong");

  a_pos_wire_read: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == slcr_pkg::ADDR_CABLE_FAULT_STATUS
    |=> reg_rdata[1:0] == $past(stat_q[1:0]) && reg_rdata[7:4] == 4'h0)
    else $error("positive wire field or pad wrong");

  a_status_read_only: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == slcr_pkg::ADDR_CABLE_FAULT_STATUS
    |=> $stable(rsv6_q) && $stable(swing_q))
    else $error("status write disturbed state");

  a_fault_word_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    flt_s2_q != flt_s3_q |=> $stable(stat_q))
    else $error("fault status took an unsettled code");

  a_read_data_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stood past its cycle");
endmodule

/* File: slcr_cable_monitor.sv */
// cable fault monitor model driving the asynchronous wire fault codes
`timescale 1ns/100ps
module slcr_cable_monitor (
  // commanded wire states
  input wire logic [1:0] neg_code,
  input wire logic [1:0] pos_code,
  // fault code lines toward the register bank
  output wire logic [1:0] neg_wire_fault_in,
  output wire logic [1:0] pos_wire_fault_in
);
  // codes move off the register clock, unrelated in phase
  assign #7 neg_wire_fault_in = neg_code;
  assign #11 pos_wire_fault_in = pos_code;
endmodule

/* File: testbench.sv */
// self-checking bench for the link configuration register bank
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] neg_code = 2'h2;
  logic [1:0] pos_code = 2'h2;
  logic [1:0] neg_wire_fault_in;
  logic [1:0] pos_wire_fault_in;
  logic addr_byte_skip;
  logic filter_loop_off;
  logic [1:0] output_swing_level;
  logic [8:0] swing_mv;
  logic swing_code_bad;
  logic [3:0] emphasis_setting;
  logic [8:0] mv_tab [4] = '{9'h000, 9'h0C8, 9'h12C, 9'h190};
  int n_errors = 0;
  int n_compared = 0;

  always #25 core_clk = ~core_clk;

  slcr_regs DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .neg_wire_fault_in, .pos_wire_fault_in,
    .addr_byte_skip, .filter_loop_off, .output_swing_level, .swing_mv,
    .swing_code_bad, .emphasis_setting);
  slcr_cable_monitor u_mon (.neg_code, .pos_code, .neg_wire_fault_in,
    .pos_wire_fault_in);

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp,
    input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {1'b0, exp}, {1'b0, reg_rdata});
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("skip", 9'h000, {8'h00, addr_byte_skip});
    chk("mv", 9'h190, swing_mv);
    chk("swing", 9'h003, {7'h00, output_swing_level});
    chk("bad", 9'h000, {8'h00, swing_code_bad});
    chk("floff", 9'h001, {8'h00, filter_loop_off});
    chk("emph", 9'h000, {5'h00, emphasis_setting});
    rchk("config", 8'h05, 8'h70);
    @(posedge core_clk);
    #1;
    chk("rdata idle", 9'h000, {1'b0, reg_rdata});
    rchk("rsvd6", 8'h06, 8'h40);
    rchk("rsvd7", 8'h07, 8'h22);
    rchk("rsvd12", 8'h0C, 8'h70);
    rchk("status", 8'h08, 8'h0A);
    $display("test reset values done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, {2'b10, c[1:0], 4'hC});
      chk("skip", 9'h001, {8'h00, addr_byte_skip});
      chk("swing", 9'(c), {7'h00, output_swing_level});
      chk("mv", mv_tab[c], swing_mv);
      chk("bad", {8'h00, c == 0}, {8'h00, swing_code_bad});
      chk("emph", 9'h00C, {5'h00, emphasis_setting});
      chk("floff", 9'h000, {8'h00, filter_loop_off});
      rchk("config", 8'h05, {2'b10, c[1:0], 4'hC});
    end
    wr(8'h05, 8'h40);
    chk("skip", 9'h000, {8'h00, addr_byte_skip});
    chk("bad", 9'h001, {8'h00, swing_code_bad});
    chk("floff", 9'h001, {8'h00, filter_loop_off});
    wr(8'h06, 8'hA5);
    rchk("rsvd6 rw", 8'h06, 8'hA5);
    $display("test config byte done");
    for (int f = 0; f < 16; f++) begin
      neg_code <= f[3:2];
      pos_code <= f[1:0];
      repeat (4) @(posedge core_clk);
      rchk("status", 8'h08, {4'h0, f[3:0]});
    end
    wr(8'h08, 8'hFF);
    rchk("status ro", 8'h08, 8'h0F);
    rchk("unmapped", 8'h09, 8'h00);
    $display("test fault status done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("skip", 9'h000, {8'h00, addr_byte_skip});
    chk("mv", 9'h190, swing_mv);
    chk("bad", 9'h000, {8'h00, swing_code_bad});
    rchk("config", 8'h05, 8'h70);
    rchk("rsvd6", 8'h06, 8'h40);
    $display("test second reset done");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    $display("[FAIL] run length expected end seen limit");
    tally_and_finish();
  end
endmodule
